// ---- rtl/nebb_ecc_ctrl.sv ----
// sector ecc control with bypass mode and bad block marker check
`timescale 1ns/1ns
`default_nettype none
module nebb_ecc_ctrl
    import nebb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [nebb_pkg::CFG_W-1:0] i_sys_cfg1,
    input wire logic i_start,
    input wire nebb_pkg::nebb_cmd_t i_cmd,
    input wire nebb_pkg::nebb_word_t i_prg_in,
    input wire nebb_pkg::nebb_word_t i_arr_in,
    output nebb_pkg::nebb_word_t o_pb_out,
    output logic [nebb_pkg::PAGE_W-1:0] o_pb_page,
    output nebb_pkg::nebb_word_t o_buf_out,
    output nebb_pkg::nebb_stat_t o_status,
    output logic o_load_err,
    output logic o_busy,
    output logic o_done
);
    import nebb_pkg::*;

    typedef struct packed {
        nebb_state_t state;
        logic bypass;
        nebb_cmd_t cmd;
        logic [IDX_W-1:0] cnt;
        logic [CODE_W-1:0] acc;
        logic [CODE_W-1:0] stored;
        logic [TOTAL_WORDS-1:0][DATA_W-1:0] mem;
        logic marker_bad;
        nebb_word_t pb_out;
        logic [PAGE_W-1:0] pb_page;
        nebb_word_t buf_out;
        nebb_stat_t status;
        logic load_err;
        logic busy;
        logic done;
    } nebb_ctrl_t;

    nebb_ctrl_t st_q;
    nebb_ctrl_t st_d;
    logic [DATA_W-1:0] gen_word;
    logic [CODE_W-1:0] gen_code;
    logic marker_bad;
    logic [CODE_W-1:0] syndrome;
    logic single_err;
    logic double_err;
    logic [DATA_W-1:0] flip_mask;
    logic [DATA_W-1:0] cur_word;
    logic is_main;

    assign gen_word = (st_q.state == NEBB_LDIN) ? i_arr_in.data : i_prg_in.data;
    assign cur_word = st_q.mem[st_q.cnt];
    assign is_main = (st_q.cnt <= IDX_MAIN_LAST);

    nebb_code_gen u_code_gen (
        .i_word(gen_word),
        .i_idx(st_q.cnt[MIDX_W-1:0]),
        .o_code(gen_code)
    );

    nebb_marker_chk u_marker_chk (
        .i_cmd(st_q.cmd),
        .i_word(i_arr_in.data),
        .o_bad(marker_bad)
    );

    // syndrome of recomputed against stored code
    always_comb
    begin
        syndrome = st_q.acc ^ st_q.stored;
        single_err = syndrome[CODE_W-1];
        double_err = !syndrome[CODE_W-1] && (syndrome[POS_W-1:0] != '0);
        flip_mask = '0;
        if (single_err && !st_q.bypass && is_main && (syndrome[POS_W-1:BIT_W] == st_q.cnt[MIDX_W-1:0]))
        begin
            flip_mask[syndrome[BIT_W-1:0]] = 1'b1;
        end
    end

    always_comb
    begin
        st_d = st_q;
        st_d.done = 1'b0;
        st_d.pb_out.valid = 1'b0;
        st_d.buf_out.valid = 1'b0;
        case (st_q.state)
            NEBB_IDLE:
            begin
                if (i_start)
                begin
                    st_d.cmd = i_cmd;
                    st_d.bypass = i_sys_cfg1[CFG_BYPASS_BIT];
                    st_d.cnt = IDX_FIRST;
                    st_d.acc = '0;
                    st_d.stored = '0;
                    st_d.marker_bad = 1'b0;
                    st_d.busy = 1'b1;
                    if (i_cmd.load)
                    begin
                        st_d.load_err = 1'b0;
                        st_d.status = '0;
                        st_d.state = NEBB_LDIN;
                    end
                    else
                    begin
                        st_d.pb_page = i_cmd.page;
                        st_d.state = NEBB_PRG;
                    end
                end
            end
            NEBB_PRG:
            begin
                if (i_prg_in.valid)
                begin
                    st_d.pb_out.valid = 1'b1;
                    st_d.pb_out.data = i_prg_in.data;
                    if (is_main && !st_q.bypass)
                    begin
                        st_d.acc = st_q.acc ^ gen_code;
                    end
                    if (st_q.cnt == IDX_ECC)
                    begin
                        // all ones leaves the programmed cells untouched
                        st_d.pb_out.data = st_q.bypass ? WORD_ERASED : {CODE_PAD, st_q.acc};
                    end
                    st_d.cnt = st_q.cnt + IDX_ONE;
                    if (st_q.cnt == IDX_LAST)
                    begin
                        st_d.busy = 1'b0;
                        st_d.done = 1'b1;
                        st_d.state = NEBB_IDLE;
                    end
                end
            end
            NEBB_LDIN:
            begin
                if (i_arr_in.valid)
                begin
                    st_d.mem[st_q.cnt] = i_arr_in.data;
                    if (is_main && !st_q.bypass)
                    begin
                        st_d.acc = st_q.acc ^ gen_code;
                    end
                    if (st_q.cnt == IDX_ECC)
                    begin
                        st_d.stored = i_arr_in.data[CODE_W-1:0];
                    end
                    if (st_q.cnt == IDX_MARKER)
                    begin
                        st_d.marker_bad = marker_bad;
                    end
                    st_d.cnt = st_q.cnt + IDX_ONE;
                    if (st_q.cnt == IDX_LAST)
                    begin
                        st_d.state = NEBB_LDOUT;
                    end
                end
            end
            NEBB_LDOUT:
            begin
                st_d.buf_out.valid = 1'b1;
                st_d.buf_out.data = cur_word ^ flip_mask;
                st_d.cnt = st_q.cnt + IDX_ONE;
                if (st_q.cnt == IDX_LAST)
                begin
                    st_d.status.valid = !st_q.bypass;
                    st_d.status.corrected = single_err && !st_q.bypass;
                    st_d.status.uncorrectable = double_err && !st_q.bypass;
                    st_d.status.pos = st_q.bypass ? '0 : syndrome[POS_W-1:0];
                    st_d.load_err = st_q.marker_bad;
                    st_d.busy = 1'b0;
                    st_d.done = 1'b1;
                    st_d.state = NEBB_IDLE;
                end
            end
            default:
            begin
                st_d.state = NEBB_IDLE;
                st_d.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign o_pb_out = st_q.pb_out;
    assign o_pb_page = st_q.pb_page;
    assign o_buf_out = st_q.buf_out;
    assign o_status = st_q.status;
    assign o_load_err = st_q.load_err;
    assign o_busy = st_q.busy;
    assign o_done = st_q.done;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_start_idle;
        (st_q.state == NEBB_IDLE) && i_start;
    endsequence

    sequence s_marker_hit;
        (st_q.state == NEBB_LDIN) && i_arr_in.valid && (st_q.cnt == IDX_MARKER) && marker_bad;
    endsequence

    sequence s_ld_done;
        o_done && !o_busy;
    endsequence

    a_cfg_sampled: assert property (s_start_idle |=> st_q.bypass == $past(i_sys_cfg1[CFG_BYPASS_BIT]))
        else $error("bypass not taken from configuration bit");
    a_bypass_held: assert property (o_busy && $past(o_busy) |-> $stable(st_q.bypass))
        else $error("bypass changed during operation");
    a_bypass_no_code: assert property ((st_q.state == NEBB_PRG) && st_q.bypass && i_prg_in.valid
        && (st_q.cnt == IDX_ECC) |=> o_pb_out.valid && (o_pb_out.data == WORD_ERASED))
        else $error("bypass program wrote a fresh code");
    a_bypass_no_gen: assert property ((st_q.state != NEBB_IDLE) && st_q.bypass |=> $stable(st_q.acc))
        else $error("code generated in bypass mode");
    a_bypass_status: assert property (o_done && st_q.cmd.load && st_q.bypass
        |-> !o_status.valid && (o_status.pos == '0) && !o_status.corrected)
        else $error("bypass load reported a valid result");
    a_bypass_raw: assert property ((st_q.state == NEBB_LDOUT) && st_q.bypass
        |=> o_buf_out.data == $past(cur_word))
        else $error("bypass load altered data");
    a_code_kept: assert property ((st_q.state == NEBB_LDOUT) && (st_q.cnt == IDX_ECC)
        |=> o_buf_out.data == $past(cur_word))
        else $error("stored code not returned to buffer");
    a_normal_valid: assert property (o_done && st_q.cmd.load && !st_q.bypass |-> o_status.valid)
        else $error("normal load left status invalid");
    a_block0_clean: assert property (o_done && st_q.cmd.load && (st_q.cmd.blk == BLOCK_SAFE) |-> !o_load_err)
        else $error("block zero reported a load error");
    a_marker_err: assert property (s_marker_hit ##1 (st_q.state == NEBB_LDIN) [*3]
        ##[1:12] s_ld_done |-> o_load_err)
        else $error("bad marker not reported");
    a_page_held: assert property (o_busy && $past(o_busy) |-> $stable(o_pb_page))
        else $error("target page moved during program");

    sequence s_ldin_last;
        (st_q.state == NEBB_LDIN) && i_arr_in.valid && (st_q.cnt == IDX_LAST);
    endsequence

    sequence s_ldout_run;
        (st_q.state == NEBB_LDOUT) [*8] ##1 (o_done && o_buf_out.valid);
    endsequence

    sequence s_fix_hit;
        (st_q.state == NEBB_LDOUT) && !st_q.bypass && single_err && is_main
            && (syndrome[POS_W-1:BIT_W] == st_q.cnt[MIDX_W-1:0]);
    endsequence

    sequence s_prg_word;
        (st_q.state == NEBB_PRG) && i_prg_in.valid;
    endsequence

    // operation framing
    a_busy_start: assert property (s_start_idle |=> o_busy && !o_done)
        else $error("start not followed by busy");
    a_done_pulse: assert property (o_done |=> !o_done)
        else $error("done longer than one cycle");
    a_status_hold: assert property (!o_busy && !$past(o_busy)
        |-> $stable(o_status) && $stable(o_load_err))
        else $error("result changed while idle");
    a_load_clear: assert property (s_start_idle ##0 i_cmd.load |=> (o_status == '0) && !o_load_err)
        else $error("load start kept old result");

    // load replay and correction
    a_ldout_len: assert property (s_ldin_last |=> s_ldout_run)
        else $error("buffer replay length wrong");
    a_single_fix: assert property (s_fix_hit
        |=> o_buf_out.data == ($past(cur_word) ^ (DATA_W'(1) << $past(syndrome[BIT_W-1:0]))))
        else $error("single bit error not repaired");
    a_uncorr: assert property ((st_q.state == NEBB_LDOUT) && (st_q.cnt == IDX_LAST) && !st_q.bypass
        && double_err |=> o_status.uncorrectable && !o_status.corrected)
        else $error("double error not flagged");
    a_bypass_no_fix: assert property ((st_q.state == NEBB_LDOUT) && st_q.bypass |-> flip_mask == '0)
        else $error("bypass load applied a repair");
    a_marker_block0: assert property ((st_q.cmd.blk == BLOCK_SAFE) |-> !marker_bad)
        else $error("block zero flagged bad");

    // program path
    a_prg_echo: assert property (s_prg_word ##0 (st_q.cnt != IDX_ECC)
        |=> o_pb_out.valid && (o_pb_out.data == $past(i_prg_in.data)))
        else $error("program word altered");
    a_prg_page: assert property (s_prg_word |-> o_pb_page == st_q.cmd.page)
        else $error("program aimed at wrong page");
    a_nobuf_prg: assert property ((st_q.state == NEBB_PRG) |=> !o_buf_out.valid)
        else $error("buffer written during program");
    a_nopb_load: assert property (st_q.cmd.load && o_busy |=> !o_pb_out.valid)
        else $error("array written during load");
endmodule : nebb_ecc_ctrl
`default_nettype wire

// ---- rtl/nebb_pkg.sv ----
// constants and types of the flash ecc bypass and bad block path
// Summary of operation
// - bypass skips background code generation
// - bypass result carries no error position
// - bypass program leaves stored spare code
// - bypass load computes no new code
// - bypass load marks status invalid
// - bypass neither detects nor corrects errors
// - configuration bit nine selects bypass mode
// - load returns originally programmed code to buffer
// - normal load compares codes, fixes single bit
// - block zero is always valid
// - bad blocks carry non erased marker word
// - marker load of bad block reports error
// - failed page program spares other pages
// - single bit main word load errors fixed by correction outside bypass
package nebb_pkg;
    localparam int DATA_W = 16;
    localparam int SECT_WORDS = 4;
    localparam int SPARE_WORDS = 4;
    localparam int TOTAL_WORDS = SECT_WORDS + SPARE_WORDS;
    localparam int IDX_W = 3;
    localparam int MIDX_W = 2;
    localparam int BIT_W = 4;
    localparam int POS_W = MIDX_W + BIT_W;
    localparam int CODE_W = POS_W + 1;
    localparam int BLK_W = 10;
    localparam int PAGE_W = 6;
    localparam int SECT_W = 2;
    localparam int MARK_W = 12;
    localparam int CFG_W = 16;
    localparam int CFG_BYPASS_BIT = 9;
    localparam logic [IDX_W-1:0] IDX_FIRST = 3'h0;
    localparam logic [IDX_W-1:0] IDX_ONE = 3'h1;
    localparam logic [IDX_W-1:0] IDX_MAIN_LAST = 3'h3;
    localparam logic [IDX_W-1:0] IDX_MARKER = 3'h4;
    localparam logic [IDX_W-1:0] IDX_ECC = 3'h5;
    localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;
    localparam logic [MARK_W-1:0] MARK_ERASED = 12'hfff;
    localparam logic [DATA_W-1:0] WORD_ERASED = 16'hffff;
    localparam logic [DATA_W-CODE_W-1:0] CODE_PAD = 9'h1ff;
    localparam logic [BLK_W-1:0] BLOCK_SAFE = 10'h000;
    localparam logic [PAGE_W-1:0] MARK_PAGE_LAST = 6'h01;
    localparam logic [SECT_W-1:0] MARK_SECTOR = 2'h0;

    typedef enum logic [1:0] {
        NEBB_IDLE = 2'b00,
        NEBB_PRG = 2'b01,
        NEBB_LDIN = 2'b10,
        NEBB_LDOUT = 2'b11
    } nebb_state_t;

    typedef struct packed {
        logic load;
        logic [BLK_W-1:0] blk;
        logic [PAGE_W-1:0] page;
        logic [SECT_W-1:0] sector;
    } nebb_cmd_t;

    typedef struct packed {
        logic valid;
        logic corrected;
        logic uncorrectable;
        logic [POS_W-1:0] pos;
    } nebb_stat_t;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } nebb_word_t;
endpackage : nebb_pkg

// ---- rtl/nebb_code_gen.sv ----
// code contribution of one main word: position xor and parity
`timescale 1ns/1ns
`default_nettype none
module nebb_code_gen
    import nebb_pkg::*;
(
    input wire logic [nebb_pkg::DATA_W-1:0] i_word,
    input wire logic [nebb_pkg::MIDX_W-1:0] i_idx,
    output logic [nebb_pkg::CODE_W-1:0] o_code
);
    always_comb
    begin
        logic [POS_W-1:0] pos;
        pos = '0;
        for (int b = 0; b < DATA_W; b++)
        begin
            if (i_word[b])
            begin
                pos = pos ^ {i_idx, BIT_W'(b)};
            end
        end
        o_code = {^i_word, pos};
    end
endmodule : nebb_code_gen
`default_nettype wire

// ---- rtl/nebb_marker_chk.sv ----
// flags a non erased bad block marker on a marker page
`timescale 1ns/1ns
`default_nettype none
module nebb_marker_chk
    import nebb_pkg::*;
(
    input wire nebb_pkg::nebb_cmd_t i_cmd,
    input wire logic [nebb_pkg::DATA_W-1:0] i_word,
    output logic o_bad
);
    always_comb
    begin
        o_bad = (i_cmd.blk != BLOCK_SAFE) &&
                (i_cmd.page <= MARK_PAGE_LAST) &&
                (i_cmd.sector == MARK_SECTOR) &&
                (i_word[MARK_W-1:0] != MARK_ERASED);
    end
endmodule : nebb_marker_chk
`default_nettype wire

// ---- tb/nebb_flash_model.sv ----
// flash page buffer model: stores one programmed sector and replays it on load
`timescale 1ns/1ns
`default_nettype none
module nebb_flash_model
    import nebb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire nebb_pkg::nebb_word_t i_pb,
    input wire logic i_go,
    input wire logic [15:0] i_flip,
    input wire logic [2:0] i_flip_idx,
    output nebb_pkg::nebb_word_t o_arr
);
    logic [15:0] mem [8];
    logic [2:0] wr_idx;
    logic [3:0] rd_cnt;
    always @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            wr_idx <= 3'h0;
            rd_cnt <= 4'h0;
            o_arr <= '0;
            for (int i = 0; i < 8; i++)
            begin
                mem[i] <= 16'hffff; // erased; no erase path later, so bad markers survive
            end
        end
        else
        begin
            if (i_pb.valid)
            begin
                mem[wr_idx] <= mem[wr_idx] & i_pb.data; // programming only clears bits
                wr_idx <= wr_idx + 3'h1;
            end
            if (i_go || (rd_cnt != 4'h0 && rd_cnt != 4'h8))
            begin
                o_arr.valid <= 1'b1;
                o_arr.data <= mem[rd_cnt[2:0]] ^ ((rd_cnt[2:0] == i_flip_idx) ? i_flip : 16'h0);
                rd_cnt <= rd_cnt + 4'h1;
            end
            else
            begin
                o_arr.valid <= 1'b0;
                o_arr.data <= ~o_arr.data; // released lines keep changing
                rd_cnt <= 4'h0;
            end
        end
    end
endmodule : nebb_flash_model
`default_nettype wire

// ---- tb/nebb_ecc_ctrl_bench.sv ----
// testbench of the sector ecc control block
`timescale 1ns/1ns
`default_nettype none
module nebb_ecc_ctrl_bench;
    import nebb_pkg::*;
    logic clk, resetn, start, go, busy, done, load_err;
    logic [15:0] cfg, flip;
    logic [2:0] flip_idx;
    logic [5:0] pb_page;
    nebb_cmd_t cmd;
    nebb_word_t prg, arr, pb_out, buf_out;
    nebb_stat_t status;
    logic [15:0] wr [8];
    logic [15:0] stor [8];
    logic [15:0] pb_cap [8];
    logic [15:0] bo_cap [8];
    int pb_n, bo_n, cyc, err_total, total_checks;

    nebb_ecc_ctrl nebb_ecc_ctrl_inst (.i_clk(clk), .i_resetn(resetn), .i_sys_cfg1(cfg), .i_start(start),
        .i_cmd(cmd), .i_prg_in(prg), .i_arr_in(arr), .o_pb_out(pb_out), .o_pb_page(pb_page),
        .o_buf_out(buf_out), .o_status(status), .o_load_err(load_err), .o_busy(busy), .o_done(done));
    nebb_flash_model nebb_flash_model_inst (.i_clk(clk), .i_resetn(resetn), .i_pb(pb_out), .i_go(go),
        .i_flip(flip), .i_flip_idx(flip_idx), .o_arr(arr));

    always #25 clk = ~clk;

    always @(posedge clk)
    begin
        if (pb_out.valid === 1'b1)
        begin
            pb_cap[pb_n % 8] = pb_out.data;
            pb_n++;
        end
        if (buf_out.valid === 1'b1)
        begin
            bo_cap[bo_n % 8] = buf_out.data;
            bo_n++;
        end
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [15:0] code_of(input logic [15:0] w [8]);
        logic [5:0] p;
        logic par;
        p = 6'h0;
        par = 1'b0;
        for (int i = 0; i < 4; i++)
            for (int b = 0; b < 16; b++)
                if (w[i][b])
                begin
                    p = p ^ {2'(i), 4'(b)};
                    par = ~par;
                end
        return {CODE_PAD, par, p};
    endfunction : code_of

    task automatic run_op(input logic ld, input logic [9:0] blk, input logic [5:0] pg, input logic byp);
        int n;
        cfg = byp ? 16'h0200 : 16'h0000;
        cmd = '{ld, blk, pg, 2'h0};
        start = 1'b1;
        go = ld;
        pb_n = 0;
        bo_n = 0;
        @(posedge clk);
        #1;
        start = 1'b0;
        go = 1'b0;
        cfg = ~cfg; // setting change mid-operation must be ignored
        check("busy", {15'h0, busy}, 16'h1);
        for (n = 0; n < 8 && !ld; n++)
        begin
            prg = '{1'b1, wr[n]};
            @(posedge clk);
            #1;
        end
        prg = '0;
        for (n = 0; n < 40 && done !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
        check("done", {15'h0, done}, 16'h1);
        @(posedge clk);
        #1;
    endtask : run_op

    task automatic t_prg(input logic [9:0] blk, input logic [5:0] pg, input logic byp);
        logic [15:0] e;
        run_op(1'b0, blk, pg, byp);
        check("pb_count", 16'(pb_n), 16'h8);
        check("pb_page", {10'h0, pb_page}, {10'h0, pg});
        for (int k = 0; k < 8; k++)
        begin
            e = (k != 5) ? wr[k] : byp ? WORD_ERASED : code_of(wr);
            check("pb_word", pb_cap[k], e);
            stor[k] = stor[k] & e;
        end
        $display("program test done, bypass %0d", byp);
    endtask : t_prg

    task automatic t_load(input logic [9:0] blk, input logic [5:0] pg, input logic byp, input logic [2:0] fi,
                          input logic [3:0] fb, input logic fen, input logic err);
        logic [15:0] m;
        m = fen ? (16'h1 << fb) : 16'h0;
        flip = m;
        flip_idx = fi;
        run_op(1'b1, blk, pg, byp);
        check("bo_count", 16'(bo_n), 16'h8);
        for (int k = 0; k < 8; k++)
            check("buf_word", bo_cap[k], (byp && k == fi) ? stor[k] ^ m : stor[k]);
        check("status", {7'h0, status}, byp ? 16'h0 : {7'h0, 1'b1, fen, 1'b0, fen ? {fi[1:0], fb} : 6'h0});
        check("load_err", {15'h0, load_err}, {15'h0, err});
        $display("load test done, block %0d page %0d bypass %0d", blk, pg, byp);
    endtask : t_load

    task automatic t_dbl();
        flip = 16'h0011;
        flip_idx = 3'h0;
        run_op(1'b1, 10'h005, 6'h02, 1'b0);
        check("bo_count", 16'(bo_n), 16'h8);
        for (int k = 0; k < 8; k++)
            check("buf_word", bo_cap[k], (k == 0) ? stor[k] ^ 16'h0011 : stor[k]);
        check("status", {7'h0, status}, {7'h0, 1'b1, 1'b0, 1'b1, 6'h04});
        $display("double error test done");
    endtask : t_dbl

    initial
    begin
        clk = 1'b0;
        resetn = 1'b0;
        cfg = 16'h0; // correction on unless a test asks for bypass
        start = 1'b0;
        cmd = '0;
        prg = '0;
        go = 1'b0;
        flip = 16'h0;
        flip_idx = 3'h0;
        wr = '{16'h1234, 16'h00f0, 16'h8001, 16'h5a5a, 16'h0a5a, 16'h0000, 16'hbeef, 16'h7777};
        stor = '{default: 16'hffff};
        repeat (16) @(posedge clk);
        #1;
        check("reset_out", {14'h0, busy, done}, 16'h0);
        resetn = 1'b1;
        @(posedge clk);
        #1;
        t_prg(10'h003, 6'h01, 1'b0); // block 3 now carries a bad marker
        t_load(10'h003, 6'h01, 1'b0, 3'h0, 4'h0, 1'b0, 1'b1); // marker scan before use
        t_load(10'h003, 6'h01, 1'b0, 3'h2, 4'h7, 1'b1, 1'b1);
        t_load(10'h000, 6'h01, 1'b0, 3'h3, 4'hf, 1'b1, 1'b0);
        t_load(10'h005, 6'h02, 1'b0, 3'h1, 4'h4, 1'b1, 1'b0); // bad block 3 mapped out
        t_dbl();
        t_prg(10'h005, 6'h05, 1'b1); // contents moved to a fresh block, block 3 retired
        t_load(10'h005, 6'h05, 1'b1, 3'h1, 4'h4, 1'b1, 1'b0);
        stop_test();
    end
endmodule : nebb_ecc_ctrl_bench
`default_nettype wire
